// ==== ddss_top.sv ====
// Display DRAM strobe sequencer top: arbitration and two bank sequencers
`timescale 1ns/1ns
module display_dram_strobe_sequencer
	import ddss_pkg::*;
#(
	parameter int ADDR_W = DDSS_ADDR_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// CPU read request
	input wire logic cpu_req,
	input wire logic cpu_bank,
	input wire logic [ADDR_W-1:0] cpu_row,
	input wire logic [ADDR_W-1:0] cpu_col,
	// CRT fetch request
	input wire logic crt_req,
	input wire logic crt_page,
	input wire logic [3:0] crt_burst_len,
	input wire logic crt_bank,
	input wire logic [ADDR_W-1:0] crt_row,
	input wire logic [ADDR_W-1:0] crt_col,
	// Refresh request
	input wire logic ref_req,
	input wire logic ref_cbr,
	input wire logic [ADDR_W-1:0] ref_row,
	input wire logic pd_mode,
	input wire logic ext_refresh_n,
	// Grants and word completion
	output logic cpu_ack,
	output logic crt_ack,
	output logic ref_ack,
	output logic word_done,
	// DRAM pins
	output logic row_strobe_bank_a,
	output logic row_strobe_bank_b,
	output logic col_strobe_bank_a,
	output logic col_strobe_bank_b,
	output logic out_enable_bank_a,
	output logic out_enable_bank_b,
	output logic [ADDR_W-1:0] mem_mux_addr
);
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
		$error("ADDR_W out of range");
	end

	// ************************************************
	// Arbitration: refresh, then CRT, then CPU
	// ************************************************
	logic [1:0] start;
	logic [1:0] busy;
	logic [1:0] done;
	logic any_busy;
	logic grant_ok;
	ddss_req_e kind;
	logic bank;
	logic [3:0] blen;
	logic [ADDR_W-1:0] col_r;
	logic [ADDR_W-1:0] row_sel;
	logic [ADDR_W-1:0] col_sel;
	ddss_strobe_s strobe [2];
	logic launch_r;

	// Single-sequence arbitration avoids bank collisions on shared address
	assign any_busy = |busy || launch_r;
	assign grant_ok = !any_busy && !(pd_mode && !ext_refresh_n);

	always_comb begin
		kind = DDSS_REQ_CPU_RD;
		bank = cpu_bank;
		blen = 4'h0;
		row_sel = cpu_row;
		col_sel = cpu_col;
		if (ref_req) begin
			kind = ref_cbr ? DDSS_REQ_CBR : DDSS_REQ_ROR;
			bank = 1'b0;
			row_sel = ref_row;
			col_sel = ref_row;
		end else if (crt_req) begin
			kind = crt_page ? DDSS_REQ_PAGE_RD : DDSS_REQ_CRT_RD;
			bank = crt_bank;
			blen = crt_burst_len;
			row_sel = crt_row;
			col_sel = crt_col;
		end
	end

	ddss_req_e kind_r;
	logic bank_r;
	logic [3:0] blen_r;
	logic refresh_both;

	// Refresh drives both banks together; reads use one bank
	assign refresh_both = (kind_r == DDSS_REQ_ROR) || (kind_r == DDSS_REQ_CBR);
	assign start[0] = launch_r && (refresh_both || !bank_r);
	assign start[1] = launch_r && (refresh_both || bank_r);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			launch_r <= 1'b0;
			kind_r <= DDSS_REQ_CPU_RD;
			bank_r <= 1'b0;
			blen_r <= '0;
			cpu_ack <= 1'b0;
			crt_ack <= 1'b0;
			ref_ack <= 1'b0;
			mem_mux_addr <= '0;
			col_r <= '0;
		end else begin
			launch_r <= 1'b0;
			cpu_ack <= 1'b0;
			crt_ack <= 1'b0;
			ref_ack <= 1'b0;
			if (grant_ok && (ref_req || crt_req || cpu_req)) begin
				launch_r <= 1'b1;
				kind_r <= kind;
				bank_r <= bank;
				blen_r <= blen;
				ref_ack <= ref_req;
				crt_ack <= !ref_req && crt_req;
				cpu_ack <= !ref_req && !crt_req;
				// Row address leads the row strobe by three periods
				mem_mux_addr <= row_sel;
				col_r <= col_sel;
			end else if (|done || (any_busy && !launch_r
				&& !(row_strobe_bank_a && row_strobe_bank_b))) begin
				// One period after the row pin falls, so the row address is held
				mem_mux_addr <= col_r;
			end
		end
	end

	// ************************************************
	// Bank sequencers
	// ************************************************
	for (genvar b = 0; b < 2; b++) begin : g_bank
		ddss_bank_seq u_seq (
			.clk(clk),
			.rst_n(rst_n),
			.start(start[b]),
			.kind(kind_r),
			.burst_len(blen_r),
			.pd_mode(pd_mode),
			.ext_refresh_n(ext_refresh_n),
			.busy(busy[b]),
			.word_done(done[b]),
			.strobe(strobe[b])
		);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_done <= 1'b0;
			row_strobe_bank_a <= 1'b1;
			row_strobe_bank_b <= 1'b1;
			col_strobe_bank_a <= 1'b1;
			col_strobe_bank_b <= 1'b1;
			out_enable_bank_a <= 1'b1;
			out_enable_bank_b <= 1'b1;
		end else begin
			word_done <= |done;
			row_strobe_bank_a <= strobe[0].row_n;
			row_strobe_bank_b <= strobe[1].row_n;
			col_strobe_bank_a <= strobe[0].col_n;
			col_strobe_bank_b <= strobe[1].col_n;
			out_enable_bank_a <= strobe[0].oe_n;
			out_enable_bank_b <= strobe[1].oe_n;
		end
	end
endmodule

// ==== ddss_pkg.sv ====
// Package of constants and carriers for the display DRAM strobe sequencer
package ddss_pkg;
	// ************************************************
	// Timing counts in memory-clock periods, then address and counter widths
	// ************************************************
	localparam int DDSS_RD_ROW_LOW = 5;
	localparam int DDSS_RD_COL_DLY = 2;
	localparam int DDSS_RD_CYCLE = 9;
	localparam int DDSS_OE_DLY = 1;
	localparam int DDSS_PG_CYCLE = 5;
	localparam int DDSS_PG_COL_HIGH = 2;
	localparam int DDSS_PG_FIRST_EXTRA = 2;
	localparam int DDSS_PG_PRECHARGE = 4;
	localparam int DDSS_ROR_ADDR_SETUP = 1;
	localparam int DDSS_ROR_ROW_LOW = 5;
	localparam int DDSS_ROR_ROW_HIGH = 4;
	localparam int DDSS_CBR_COL_LEAD = 2;
	localparam int DDSS_CBR_ROW_LOW = 5;
	localparam int DDSS_CBR_ROW_HIGH = 5;
	localparam int DDSS_CBR_COL_LOW = 4;
	localparam int DDSS_CBR_PRECHARGE = 3;
	localparam int DDSS_CBR_OE_HOLD = 30;
	localparam int DDSS_PD_STEP = 1;
	localparam int DDSS_ADDR_W = 9;
	localparam int DDSS_CNT_W = 6;
	// ************************************************
	// Request kinds and strobe carrier
	// ************************************************
	typedef enum logic [2:0] {
		DDSS_REQ_CPU_RD,
		DDSS_REQ_CRT_RD,
		DDSS_REQ_PAGE_RD,
		DDSS_REQ_ROR,
		DDSS_REQ_CBR
	} ddss_req_e;
	typedef struct packed {
		logic row_n;
		logic col_n;
		logic oe_n;
	} ddss_strobe_s;
	localparam ddss_strobe_s DDSS_STROBE_IDLE = 3'b111;
endpackage

// ==== ddss_bank_seq.sv ====
// One bank's strobe sequencer with cycle counter
`timescale 1ns/1ns
module ddss_bank_seq
	import ddss_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command
	input wire logic start,
	input wire ddss_req_e kind,
	input wire logic [3:0] burst_len,
	// Power-down refresh pacing
	input wire logic pd_mode,
	input wire logic ext_refresh_n,
	// Status and strobes
	output logic busy,
	output logic word_done,
	output ddss_strobe_s strobe
);
	// ************************************************
	// Sequence state
	// ************************************************
	typedef enum logic [2:0] {
		DDSS_S_IDLE,
		DDSS_S_READ,
		DDSS_S_PAGE,
		DDSS_S_PRE,
		DDSS_S_ROR,
		DDSS_S_CBR,
		DDSS_S_PD
	} ddss_bank_state_e;

	ddss_bank_state_e state_r;
	ddss_req_e kind_r;
	logic [DDSS_CNT_W-1:0] cnt_r;
	logic [3:0] left_r;
	logic first_r;
	logic [DDSS_CNT_W-1:0] oe_hold_r;
	logic [DDSS_CNT_W-1:0] page_len;

	function automatic logic [DDSS_CNT_W-1:0] cnt_of(input int v);
		return DDSS_CNT_W'(v);
	endfunction

	assign page_len = first_r ? cnt_of(DDSS_PG_CYCLE + DDSS_PG_FIRST_EXTRA)
		: cnt_of(DDSS_PG_CYCLE);

	// ************************************************
	// Enable hold after a column-first refresh
	// ************************************************
	// Keeps the bank busy so no read can drop the enable too soon
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			oe_hold_r <= '0;
		end else if (state_r == DDSS_S_CBR && cnt_r == cnt_of(DDSS_CBR_COL_LEAD)) begin
			oe_hold_r <= cnt_of(DDSS_CBR_OE_HOLD);
		end else if (oe_hold_r != '0) begin
			oe_hold_r <= oe_hold_r - cnt_of(1);
		end
	end

	// ************************************************
	// Sequencing
	// ************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= DDSS_S_IDLE;
			kind_r <= DDSS_REQ_CPU_RD;
			cnt_r <= '0;
			left_r <= '0;
			first_r <= 1'b0;
			strobe <= DDSS_STROBE_IDLE;
			busy <= 1'b0;
			word_done <= 1'b0;
		end else begin
			word_done <= 1'b0;
			cnt_r <= cnt_r + cnt_of(1);
			unique case (state_r)
				DDSS_S_IDLE: begin
					strobe <= DDSS_STROBE_IDLE;
					cnt_r <= '0;
					busy <= (oe_hold_r != '0);
					if (pd_mode && !ext_refresh_n) begin
						state_r <= DDSS_S_PD;
						busy <= 1'b1;
					end else if (start) begin
						kind_r <= kind;
						busy <= 1'b1;
						first_r <= 1'b1;
						left_r <= burst_len;
						unique case (kind)
							DDSS_REQ_PAGE_RD: state_r <= DDSS_S_PAGE;
							DDSS_REQ_ROR: state_r <= DDSS_S_ROR;
							DDSS_REQ_CBR: state_r <= DDSS_S_CBR;
							default: state_r <= DDSS_S_READ;
						endcase
					end
				end
				DDSS_S_READ: begin
					// Row low 0..4, column low 2..4, enable low 3..5, cycle 9
					strobe.row_n <= !(cnt_r < cnt_of(DDSS_RD_ROW_LOW));
					strobe.col_n <= !(cnt_r >= cnt_of(DDSS_RD_COL_DLY)
						&& cnt_r < cnt_of(DDSS_RD_ROW_LOW));
					strobe.oe_n <= !(cnt_r >= cnt_of(DDSS_RD_COL_DLY + DDSS_OE_DLY)
						&& cnt_r < cnt_of(DDSS_RD_ROW_LOW + DDSS_OE_DLY));
					if (cnt_r == cnt_of(DDSS_RD_ROW_LOW))
						word_done <= 1'b1;
					if (cnt_r == cnt_of(DDSS_RD_CYCLE - 1))
						state_r <= DDSS_S_IDLE;
				end
				DDSS_S_PAGE: begin
					// Column falls at 2 of each access and stays low 3 periods
					strobe.row_n <= 1'b0;
					// First access adds its two periods to the column high time
					strobe.col_n <= !(cnt_r >= cnt_of(DDSS_RD_COL_DLY)
						&& cnt_r < cnt_of(DDSS_PG_CYCLE));
					strobe.oe_n <= !(cnt_r >= cnt_of(DDSS_RD_COL_DLY + DDSS_OE_DLY)
						&& cnt_r < cnt_of(DDSS_PG_CYCLE + DDSS_OE_DLY));
					if (cnt_r == page_len - cnt_of(1)) begin
						cnt_r <= '0;
						first_r <= 1'b0;
						word_done <= 1'b1;
						left_r <= left_r - 4'h1;
						if (left_r == 4'h0) begin
							// Row rises in precharge, three periods after the column fell, five when burst_len is 0
							state_r <= DDSS_S_PRE;
						end
					end
				end
				DDSS_S_PRE: begin
					strobe <= DDSS_STROBE_IDLE;
					if (cnt_r == cnt_of(DDSS_PG_PRECHARGE - 1))
						state_r <= DDSS_S_IDLE;
				end
				DDSS_S_ROR: begin
					// Address set in idle, three periods before the row pin falls
					strobe.row_n <= !(cnt_r < cnt_of(DDSS_ROR_ROW_LOW));
					if (cnt_r == cnt_of(DDSS_ROR_ROW_LOW + DDSS_ROR_ROW_HIGH - 1))
						state_r <= DDSS_S_IDLE;
				end
				DDSS_S_CBR: begin
					// Column 0..3 low, row 2..6 low, high through 9, enable high
					strobe.oe_n <= 1'b1;
					strobe.col_n <= !(cnt_r < cnt_of(DDSS_CBR_COL_LOW));
					strobe.row_n <= !(cnt_r >= cnt_of(DDSS_CBR_COL_LEAD)
						&& cnt_r < cnt_of(DDSS_CBR_COL_LEAD + DDSS_CBR_ROW_LOW));
					if (cnt_r == cnt_of(DDSS_CBR_COL_LEAD + DDSS_CBR_ROW_LOW
						+ DDSS_CBR_PRECHARGE - 1))
						state_r <= DDSS_S_IDLE;
				end
				DDSS_S_PD: begin
					// Column follows input, then row; release in same order
					if (!ext_refresh_n) begin
						strobe.col_n <= 1'b0;
						if (!strobe.col_n)
							strobe.row_n <= 1'b0;
					end else begin
						strobe.col_n <= 1'b1;
						if (strobe.col_n) begin
							strobe.row_n <= 1'b1;
							if (strobe.row_n)
								state_r <= DDSS_S_IDLE;
						end
					end
				end
				default: state_r <= DDSS_S_IDLE;
			endcase
		end
	end
endmodule

// ==== ddss_asserts.sv ====
// Timing checker for the display DRAM strobe sequencer, bound to its top
`timescale 1ns/1ns
module ddss_asserts
	import ddss_pkg::*;
#(
	parameter int ADDR_W = DDSS_ADDR_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Requests and grants
	input wire logic cpu_ack,
	input wire logic cpu_bank,
	input wire logic crt_ack,
	input wire logic crt_page,
	input wire logic crt_bank,
	input wire logic [3:0] crt_burst_len,
	input wire logic ref_ack,
	input wire logic ref_cbr,
	input wire logic [ADDR_W-1:0] ref_row,
	input wire logic pd_mode,
	input wire logic ext_refresh_n,
	// Bank a pins
	input wire logic row_strobe_bank_a,
	input wire logic col_strobe_bank_a,
	input wire logic out_enable_bank_a,
	input wire logic [ADDR_W-1:0] mem_mux_addr
);
	// ****************
	// Bank a only, bank b shares the timing
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire ra = row_strobe_bank_a;
	wire ca = col_strobe_bank_a;
	wire oa = out_enable_bank_a;
	wire rd = (cpu_ack && !cpu_bank) || (crt_ack && !crt_page && !crt_bank);
	wire pg = crt_ack && crt_page && !crt_bank && crt_burst_len == 4'h1;
	wire ror = ref_ack && !ref_cbr;
	wire cbr = ref_ack && ref_cbr;
	wire ack = cpu_ack || crt_ack || ref_ack;
	// Counted, since the hold is longer than a repetition may be
	logic [5:0] cbr_wait_r;
	always_ff @(posedge clk) begin
		if (!rst_n)
			cbr_wait_r <= 6'h00;
		else if (cbr)
			cbr_wait_r <= 6'h24;
		else if (cbr_wait_r != 6'h00)
			cbr_wait_r <= cbr_wait_r - 6'h01;
	end
	// Pins move three edges after the grant pulse is seen
	a_rd_row_low: assert property (rd |-> ##3 !ra[*5] ##1 ra)
		else $error("read row width");
	a_rd_col_delay: assert property (rd |-> ##3 ca[*2] ##1 !ca[*3] ##1 ca)
		else $error("read column timing");
	a_rd_oe_follow: assert property (rd |-> ##3 oa[*3] ##1 !oa[*3] ##1 oa)
		else $error("read enable timing");
	a_pg_col_spacing: assert property (pg |-> ##3 ca[*2] ##1 !ca[*3]
		##1 ca[*4] ##1 !ca[*3] ##1 ca)
		else $error("page column timing");
	a_ror_row_timing: assert property (ror |-> mem_mux_addr == ref_row
		##3 !ra[*5] ##1 ra[*4])
		else $error("row-only refresh timing");
	a_cbr_col_timing: assert property (cbr |-> ##3 !ca[*4] ##1 ca[*6])
		else $error("refresh column timing");
	a_cbr_row_timing: assert property (cbr |-> ##3 ra[*2] ##1 !ra[*5] ##1 ra[*3])
		else $error("refresh row timing");
	a_cbr_oe_long: assert property (cbr_wait_r != 6'h00 |-> oa)
		else $error("refresh enable low too soon");
	a_cbr_oe_high: assert property (cbr |=> oa[*8])
		else $error("refresh enable low");
	a_pd_fall: assert property (pd_mode && $fell(ext_refresh_n) |-> ##3 !ca ##1 !ra)
		else $error("paced refresh entry");
	a_pd_rise: assert property (pd_mode && $rose(ext_refresh_n) |-> ##2 ca ##1 ra)
		else $error("paced refresh release");
	a_seq_gap: assert property (ack |=> !ack[*8])
		else $error("grant inside sequence");
endmodule
bind display_dram_strobe_sequencer ddss_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst_n,
	.cpu_ack, .cpu_bank, .crt_ack, .crt_page, .crt_bank, .crt_burst_len, .ref_ack, .ref_cbr,
	.ref_row, .pd_mode, .ext_refresh_n, .row_strobe_bank_a, .col_strobe_bank_a,
	.out_enable_bank_a, .mem_mux_addr);

// ==== ddss_dram_model.sv ====
// Behavioural page-mode DRAM bank that tallies strobe events
`timescale 1ns/1ns
module ddss_dram_model
	import ddss_pkg::*;
(
	// Strobes and address
	input wire logic row_n,
	input wire logic col_n,
	input wire logic [DDSS_ADDR_W-1:0] addr,
	// Tallies
	output logic [7:0] n_act,
	output logic [7:0] n_col,
	output logic [7:0] n_cbr,
	output logic [DDSS_ADDR_W-1:0] last_row,
	output logic [DDSS_ADDR_W-1:0] last_col
);
	initial begin
		{n_act, n_col, n_cbr} = 24'h0;
		{last_row, last_col} = '0;
	end
	// Column already low at row fall means refresh
	always @(negedge row_n) begin
		if (col_n) begin
			n_act <= n_act + 8'h01;
			last_row <= addr;
		end else begin
			n_cbr <= n_cbr + 8'h01;
		end
	end
	always @(negedge col_n) begin
		if (!row_n) begin
			n_col <= n_col + 8'h01;
			last_col <= addr;
		end
	end
endmodule

// ==== ddss_tb.sv ====
// Self-checking bench for the display DRAM strobe sequencer
`timescale 1ns/1ns
module tb;
	import ddss_pkg::*;
	// ****************
	// Pins and tallies
	// ****************
	logic clk = 1'b0;
	logic rst_n, cpu_req, cpu_bank, crt_req, crt_page, crt_bank, ref_req, ref_cbr;
	logic pd_mode, ext_refresh_n, cpu_ack, crt_ack, ref_ack, word_done;
	logic [3:0] crt_burst_len;
	logic [8:0] cpu_row, cpu_col, crt_row, crt_col, ref_row, mem_mux_addr;
	logic row_strobe_bank_a, row_strobe_bank_b, col_strobe_bank_a, col_strobe_bank_b;
	logic out_enable_bank_a, out_enable_bank_b;
	logic [7:0] act_a, act_b, ncol_a, ncol_b, cbr_a, cbr_b;
	logic [8:0] lrow_a, lrow_b, lcol_a, lcol_b;
	int errors = 0;
	int num_checks = 0;
	int n_done = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	display_dram_strobe_sequencer u_dut (.clk, .rst_n, .cpu_req, .cpu_bank, .cpu_row, .cpu_col,
		.crt_req, .crt_page, .crt_burst_len, .crt_bank, .crt_row, .crt_col, .ref_req, .ref_cbr,
		.ref_row, .pd_mode, .ext_refresh_n, .cpu_ack, .crt_ack, .ref_ack, .word_done,
		.row_strobe_bank_a, .row_strobe_bank_b, .col_strobe_bank_a, .col_strobe_bank_b,
		.out_enable_bank_a, .out_enable_bank_b, .mem_mux_addr);
	ddss_dram_model u_mem_a (.row_n(row_strobe_bank_a), .col_n(col_strobe_bank_a),
		.addr(mem_mux_addr), .n_act(act_a), .n_col(ncol_a), .n_cbr(cbr_a),
		.last_row(lrow_a), .last_col(lcol_a));
	ddss_dram_model u_mem_b (.row_n(row_strobe_bank_b), .col_n(col_strobe_bank_b),
		.addr(mem_mux_addr), .n_act(act_b), .n_col(ncol_b), .n_cbr(cbr_b),
		.last_row(lrow_b), .last_col(lcol_b));
	// Hang guard, well above the whole run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (word_done === 1'b1)
			n_done <= n_done + 1;
		if (cycles == 3000) begin
			errors++;
			close_out;
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Acks are one-cycle pulses, so look at every edge
	task grant(input logic [2:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ({ref_ack, crt_ack, cpu_ack} === 3'h0 && n < 60);
		chk("grant", 16'(exp), 16'({ref_ack, crt_ack, cpu_ack}));
		ref_req <= ref_req & ~ref_ack;
		crt_req <= crt_req & ~crt_ack;
		cpu_req <= cpu_req & ~cpu_ack;
	endtask
	task close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_cpu(input logic b, input logic [8:0] r, input logic [8:0] c);
		logic [7:0] a0, b0;
		int d0;
		a0 = act_a;
		b0 = act_b;
		d0 = n_done;
		@(posedge clk);
		cpu_bank <= b;
		cpu_row <= r;
		cpu_col <= c;
		cpu_req <= 1'b1;
		grant(3'h1);
		repeat (12) @(posedge clk);
		chk("bank a rows", 16'(a0 + {7'h00, !b}), 16'(act_a));
		chk("bank b rows", 16'(b0 + {7'h00, b}), 16'(act_b));
		chk("row addr", 16'(r), 16'(b ? lrow_b : lrow_a));
		chk("col addr", 16'(c), 16'(b ? lcol_b : lcol_a));
		chk("read done", 16'(d0 + 1), 16'(n_done));
	endtask
	task t_page;
		logic [7:0] c0;
		int d0;
		c0 = ncol_a;
		d0 = n_done;
		@(posedge clk);
		crt_page <= 1'b1;
		crt_bank <= 1'b0;
		crt_burst_len <= 4'h1;
		crt_row <= 9'h0C3;
		crt_col <= 9'h13C;
		crt_req <= 1'b1;
		grant(3'h2);
		repeat (20) @(posedge clk);
		chk("page columns", 16'(c0 + 8'h02), 16'(ncol_a));
		chk("page done", 16'(d0 + 2), 16'(n_done));
		chk("page row", 16'h00C3, 16'(lrow_a));
	endtask
	task t_ref(input logic cbr);
		logic [7:0] a0, k0;
		a0 = act_b;
		k0 = cbr_a;
		@(posedge clk);
		ref_cbr <= cbr;
		ref_row <= 9'h1FF;
		ref_req <= 1'b1;
		grant(3'h4);
		repeat (12) @(posedge clk);
		chk("cbr bank a", 16'(k0 + {7'h00, cbr}), 16'(cbr_a));
		chk("rows bank b", 16'(a0 + {7'h00, !cbr}), 16'(act_b));
		chk("refresh row", 16'h01FF, 16'(lrow_b));
	endtask
	// All three at once: refresh, then display, then processor
	task t_arb;
		@(posedge clk);
		cpu_req <= 1'b1;
		crt_req <= 1'b1;
		crt_page <= 1'b0;
		ref_req <= 1'b1;
		grant(3'h4);
		grant(3'h2);
		grant(3'h1);
		repeat (12) @(posedge clk);
	endtask
	task t_pd;
		logic [7:0] k0;
		k0 = cbr_b;
		@(posedge clk);
		pd_mode <= 1'b1;
		@(posedge clk);
		ext_refresh_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("paced low", 16'h0, 16'({row_strobe_bank_a, col_strobe_bank_b}));
		ext_refresh_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("paced high", 16'h3, 16'({row_strobe_bank_b, col_strobe_bank_a}));
		chk("paced count", 16'(k0 + 8'h01), 16'(cbr_b));
		pd_mode <= 1'b0;
	endtask
	initial begin
		{rst_n, cpu_req, cpu_bank, crt_req, crt_page, crt_bank, ref_req, ref_cbr} = 8'h00;
		pd_mode = 1'b0;
		ext_refresh_n = 1'b1;
		crt_burst_len = 4'h0;
		{cpu_row, cpu_col, crt_row, crt_col, ref_row} = 45'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("idle", 16'h0003, 16'({row_strobe_bank_a, out_enable_bank_b}));
		t_cpu(1'b0, 9'h0A5, 9'h15A);
		t_cpu(1'b1, 9'h000, 9'h1FF);
		t_page;
		t_ref(1'b0);
		t_ref(1'b1);
		t_arb;
		t_pd;
		close_out;
	end
endmodule
